/* src/trq_read_qualifier.sv */
// read front end: counting clock, transfer sequencer and nine channels
`timescale 1ns/1ps
module trq_read_qualifier #(
  parameter int unsigned CHANNELS = trq_pkg::CHANNELS,
  parameter bit SLOW_SEL_EN = 1'b0
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic osc_out,
  input wire logic fast_sel,
  input wire logic mid_sel,
  input wire logic slow_sel,
  input wire logic [CHANNELS-1:0] read_pulse_in,
  input wire logic [CHANNELS-1:0] crowding_counter_zero,
  input wire logic transfer_start,
  input wire logic transfer_end,
  input wire logic write_order,
  input wire logic phase_flag_one,
  input wire logic read_order,
  input wire logic byte_request,
  input wire logic fm_cycle_done,
  output logic div2_stage,
  output logic div4_stage,
  output logic channel_clock,
  output logic read_phase,
  output logic transfer_state_flag_a,
  output logic transfer_state_flag_b,
  output logic substate_flag_a,
  output logic substate_flag_b,
  output logic [CHANNELS-1:0] peak_transfer,
  output logic [CHANNELS-1:0] width_qualified,
  output logic [CHANNELS*trq_pkg::CROWD_W-1:0] crowd_preload
);
  logic rst_meta_q;
  logic rst_n;
  logic osc_prev_q;
  logic osc_fall;
  logic count_tick;
  logic tick_q;
  logic slow_en;
  logic [CHANNELS-1:0] pulse_meta_q;
  logic [CHANNELS-1:0] pulse_s_q;
  trq_pkg::trq_seq_t state_q;
  trq_pkg::trq_seq_t state_d;
  logic read_ok;

  // state decode shared by flags and read phase
  function automatic logic in_transfer(input trq_pkg::trq_seq_t s);
    return s != trq_pkg::TRQ_IDLE;
  endfunction : in_transfer

  // two-flop release of the external reset
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  // oscillator falling edge acts as the buffered oscillator clock
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      osc_prev_q <= 1'b0;
    end else begin
      osc_prev_q <= osc_out;
    end
  end

  assign osc_fall = osc_prev_q && !osc_out;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      div2_stage <= 1'b0;
    end else if (osc_fall) begin
      div2_stage <= !div2_stage;
    end
  end

  // second divider toggles on first stage high
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      div4_stage <= 1'b0;
    end else if (osc_fall && div2_stage) begin
      div4_stage <= !div4_stage;
    end
  end

  assign slow_en = SLOW_SEL_EN && slow_sel;

  // tick marks the falling channel clock edge
  always_comb begin
    count_tick = 1'b0;
    if (fast_sel) begin
      count_tick = osc_fall;
    end else if (mid_sel) begin
      count_tick = osc_fall && div2_stage;
    end else if (slow_en) begin
      count_tick = osc_fall && div2_stage && div4_stage;
    end
  end

  // visible channel clock, one system cycle per falling edge
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      tick_q <= 1'b0;
    end else begin
      tick_q <= count_tick;
    end
  end

  assign channel_clock = tick_q;

  // two-stage sync on the counting clock
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pulse_meta_q <= '0;
      pulse_s_q <= '0;
    end else if (count_tick) begin
      pulse_meta_q <= read_pulse_in;
      pulse_s_q <= pulse_meta_q;
    end
  end

  assign read_ok = !write_order && !phase_flag_one && read_order;

  always_comb begin
    state_d = state_q;
    case (state_q)
      trq_pkg::TRQ_IDLE: begin
        if (transfer_start) begin
          state_d = trq_pkg::TRQ_XFER;
        end
      end
      trq_pkg::TRQ_XFER: begin
        if (transfer_end) begin
          state_d = trq_pkg::TRQ_IDLE;
        end else if (byte_request) begin
          state_d = trq_pkg::TRQ_SERVICE;
        end
      end
      trq_pkg::TRQ_SERVICE: begin
        if (fm_cycle_done) begin
          state_d = trq_pkg::TRQ_XFER;
        end
      end
      default: begin
        state_d = trq_pkg::TRQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_q <= trq_pkg::TRQ_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // state decode flags, registered
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      transfer_state_flag_a <= 1'b0;
      transfer_state_flag_b <= 1'b0;
      substate_flag_a <= 1'b0;
      substate_flag_b <= 1'b0;
    end else begin
      transfer_state_flag_a <= in_transfer(state_d);
      transfer_state_flag_b <= in_transfer(state_d);
      substate_flag_a <= in_transfer(state_d);
      substate_flag_b <= state_d == trq_pkg::TRQ_XFER;
    end
  end

  // read phase only during data transfer
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      read_phase <= 1'b0;
    end else begin
      read_phase <= in_transfer(state_d) && read_ok;
    end
  end

  // one channel per parallel read line
  for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
    trq_channel u_chan (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .tick(count_tick),
      .pulse_s(pulse_s_q[ch]),
      .write_order(write_order),
      .crowding_counter_zero(crowding_counter_zero[ch]),
      .width_count_q(),
      .qual_q(width_qualified[ch]),
      .peak_transfer_q(peak_transfer[ch]),
      .preload_q(crowd_preload[ch*trq_pkg::CROWD_W +: trq_pkg::CROWD_W])
    );
  end

  div2_toggle_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    osc_fall |=> div2_stage != $past(div2_stage))
    else $error("half rate stage missed a toggle");
  div2_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !osc_fall |=> $stable(div2_stage))
    else $error("half rate stage toggled without edge");
  div4_rate_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    osc_fall && !div2_stage |=> $stable(div4_stage))
    else $error("quarter rate stage toggled early");
  div4_toggle_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    osc_fall && div2_stage |=> div4_stage != $past(div4_stage))
    else $error("quarter rate stage missed a toggle");
  fast_tick_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    fast_sel && osc_fall |=> channel_clock)
    else $error("fast select did not pass oscillator");
  fast_quiet_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    fast_sel && !osc_fall |=> !channel_clock)
    else $error("fast select ticked without edge");
  mid_tick_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !fast_sel && mid_sel && osc_fall |=> channel_clock == $past(div2_stage))
    else $error("mid select did not give half rate");
  mid_skip_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !fast_sel && mid_sel && osc_fall && !div2_stage |=> !channel_clock)
    else $error("mid select ticked on skipped edge");
  slow_disabled_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !SLOW_SEL_EN && !fast_sel && !mid_sel |=> !channel_clock)
    else $error("slow select produced a clock");
  slow_sel_off_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !SLOW_SEL_EN && !fast_sel && !mid_sel && slow_sel |=> !channel_clock)
    else $error("slow select was not ignored");
  chan_clock_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    count_tick |=> channel_clock)
    else $error("channel clock missed a tick");
  read_entry_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    read_phase |-> $past(!write_order && !phase_flag_one && read_order))
    else $error("read phase entered without read order");
  read_write_block_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    write_order |=> !read_phase)
    else $error("read phase during write order");
  read_idle_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state_q == trq_pkg::TRQ_IDLE |-> !read_phase)
    else $error("read phase outside data transfer");
  idle_flags_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state_q == trq_pkg::TRQ_IDLE |-> !transfer_state_flag_a && !transfer_state_flag_b)
    else $error("transfer flags set while idle");
  xfer_decode_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state_q == trq_pkg::TRQ_XFER |-> substate_flag_a && substate_flag_b)
    else $error("transfer state flags wrong");
  service_decode_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state_q == trq_pkg::TRQ_SERVICE |-> substate_flag_a && !substate_flag_b)
    else $error("service state flags wrong");
  xfer_service_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state_q == trq_pkg::TRQ_XFER && !transfer_end && byte_request
    |=> state_q == trq_pkg::TRQ_SERVICE)
    else $error("byte request did not reach service");
  end_idle_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state_q == trq_pkg::TRQ_XFER && transfer_end |=> state_q == trq_pkg::TRQ_IDLE)
    else $error("transfer end did not reach idle");
  service_wait_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state_q == trq_pkg::TRQ_SERVICE && !fm_cycle_done |=> state_q == trq_pkg::TRQ_SERVICE)
    else $error("service left before memory cycle end");
  service_return_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state_q == trq_pkg::TRQ_SERVICE && fm_cycle_done |=> substate_flag_b ##0
    state_q == trq_pkg::TRQ_XFER)
    else $error("service did not return to transfer");
  sync_delay_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    count_tick |=> pulse_s_q == $past(pulse_meta_q))
    else $error("pulse sync stage skipped");
  sync_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !count_tick |=> $stable(pulse_s_q))
    else $error("pulse sync moved without tick");
  reset_idle_a: assert property (@(posedge clk_sys)
    $rose(rst_n) |-> state_q == trq_pkg::TRQ_IDLE && !read_phase)
    else $error("reset left sequencer busy");
  reset_clear_a: assert property (@(posedge clk_sys)
    $rose(rst_n) |-> !div2_stage && !div4_stage && peak_transfer == '0
    && width_qualified == '0)
    else $error("reset left dividers or flags set");
endmodule : trq_read_qualifier

/* src/trq_pkg.sv */
// shared constants for the tape read peak qualifier
package trq_pkg;
  // read channels: eight data bits plus parity
  localparam int unsigned CHANNELS = 9;
  localparam int unsigned DATA_BITS = 8;
  // peak width counter and bit crowding counter widths
  localparam int unsigned CNT_W = 6;
  localparam int unsigned CROWD_W = CNT_W - 1;
  // count at which the width-qualified flag is armed
  localparam logic [CNT_W-1:0] QUAL_COUNT = 6'h07;
  localparam logic [CNT_W-1:0] CNT_RESET = 6'h00;
  localparam logic [CROWD_W-1:0] CROWD_RESET = 5'h00;
  // rates in kHz
  localparam int unsigned SYS_CLK_KHZ = 20000;
  localparam int unsigned OSC_KHZ = 3840;
  localparam int unsigned MID_KHZ = OSC_KHZ / 2;
  localparam int unsigned SLOW_KHZ = OSC_KHZ / 4;
  // least system cycles between two oscillator falling edges
  localparam int unsigned OSC_CYCLES = SYS_CLK_KHZ / OSC_KHZ;
  // sequencer states
  typedef enum logic [1:0] {
    TRQ_IDLE,
    TRQ_XFER,
    TRQ_SERVICE
  } trq_seq_t;
endpackage : trq_pkg

/* src/trq_channel.sv */
// one read channel: peak width counter, qualify and transfer flags
`timescale 1ns/1ps
module trq_channel (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic pulse_s,
  input wire logic write_order,
  input wire logic crowding_counter_zero,
  output logic [trq_pkg::CNT_W-1:0] width_count_q,
  output logic qual_q,
  output logic peak_transfer_q,
  output logic [trq_pkg::CROWD_W-1:0] preload_q
);
  logic set_qual;
  logic set_xfer;
  logic counter_clear;
  logic [trq_pkg::CNT_W-1:0] cnt_d;

  assign set_qual = (width_count_q == trq_pkg::QUAL_COUNT) && !peak_transfer_q && !write_order;
  // preload makes the crowding counter non-zero, so no second set
  assign set_xfer = qual_q && !pulse_s && crowding_counter_zero && !peak_transfer_q;
  assign counter_clear = !pulse_s && !qual_q;
  assign cnt_d = width_count_q + 6'h01;

  // count while the pulse is true
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      width_count_q <= trq_pkg::CNT_RESET;
    end else if (counter_clear) begin
      width_count_q <= trq_pkg::CNT_RESET;
    end else if (tick && (pulse_s || set_xfer)) begin
      width_count_q <= cnt_d;
    end
  end

  // reset by transfer overrides the set
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      qual_q <= 1'b0;
    end else if (tick) begin
      qual_q <= set_qual || (qual_q && !peak_transfer_q);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      peak_transfer_q <= 1'b0;
    end else if (tick) begin
      peak_transfer_q <= set_xfer || (peak_transfer_q && !peak_transfer_q);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      preload_q <= trq_pkg::CROWD_RESET;
    end else if (tick && set_xfer) begin
      preload_q <= cnt_d[trq_pkg::CNT_W-1:1];
    end
  end

  qual_at_seven_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    tick && width_count_q == 6'h07 && !peak_transfer_q && !write_order |=> qual_q)
    else $error("qualify flag missed count seven");
  noise_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !pulse_s && !qual_q |=> width_count_q == 6'h00)
    else $error("counter not cleared after noise");
  xfer_cause_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(peak_transfer_q) |-> $past(qual_q) && !$past(pulse_s) && $past(crowding_counter_zero))
    else $error("transfer set without cause");
  xfer_advance_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(peak_transfer_q) |-> width_count_q == $past(width_count_q) + 6'h01)
    else $error("counter did not advance on transfer");
  xfer_release_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    tick && peak_transfer_q |=> !peak_transfer_q && !qual_q)
    else $error("transfer flags not released");
  preload_half_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(peak_transfer_q) |-> preload_q == width_count_q[5:1])
    else $error("preload is not half the width");
  count_wrap_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    tick && pulse_s && width_count_q == 6'h3f |=> width_count_q == 6'h00)
    else $error("counter did not wrap at 64");
endmodule : trq_channel

/* verif/trq_station_model.sv */
// tape station model: crystal oscillator and nine read amplifier lines
`timescale 1ns/1ps
module trq_station_model #(
  parameter int OSC_HALF = 3
) (
  input wire logic clk_sys,
  input wire logic [3:0] req_ch,
  input wire logic [7:0] req_width,
  input wire logic req_go,
  output logic osc_out,
  output logic [8:0] read_pulse_in,
  output logic busy
);
  int phase_q = 0;
  logic [7:0] left_q = 8'h00;
  initial begin
    osc_out = 1'b1;
    read_pulse_in = 9'h000;
    busy = 1'b0;
  end
  always @(posedge clk_sys) begin
    phase_q <= (phase_q == 2 * OSC_HALF - 1) ? 0 : phase_q + 1;
    osc_out <= (phase_q < OSC_HALF);
    if (phase_q == 0 && req_go && !busy) begin
      read_pulse_in[req_ch] <= 1'b1;
      left_q <= req_width;
      busy <= 1'b1;
    end else if (phase_q == OSC_HALF && busy) begin
      left_q <= left_q - 8'h01;
    end else if (phase_q == 0 && busy && left_q == 8'h00) begin
      read_pulse_in <= 9'h000;
      busy <= 1'b0;
    end
  end
endmodule : trq_station_model

/* verif/trq_read_qualifier_test.sv */
// self-checking bench for the tape read peak qualifier
`timescale 1ns/1ps
module trq_read_qualifier_test;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic fast_sel = 1'b0, mid_sel = 1'b0, slow_sel = 1'b0, busy, req_go = 1'b0;
  logic [8:0] crowding_counter_zero = 9'h1ff, read_pulse_in, peak_transfer, width_qualified;
  logic transfer_start = 0, transfer_end = 0, write_order = 0, phase_flag_one = 0;
  logic read_order = 0, byte_request = 0, fm_cycle_done = 0, osc_out;
  logic div2_stage, div4_stage, channel_clock, read_phase;
  logic transfer_state_flag_a, transfer_state_flag_b, substate_flag_a, substate_flag_b;
  logic [44:0] crowd_preload;
  logic [3:0] req_ch = 4'h0;
  logic [7:0] req_width = 8'h00;
  logic [8:0] pt_prev = 9'h000;
  logic [4:0] last_pre = 5'h00;
  logic d2p = 1'b0, d4p = 1'b0;
  int err_total = 0, comparisons = 0, seed = 2, xfers = 0, ticks = 0, d2 = 0, d4 = 0;
  int t0, a0, b0, w;

  trq_read_qualifier u_dut (.clk_sys, .arst_n, .osc_out, .fast_sel, .mid_sel, .slow_sel,
    .read_pulse_in, .crowding_counter_zero, .transfer_start, .transfer_end, .write_order,
    .phase_flag_one, .read_order, .byte_request, .fm_cycle_done, .div2_stage, .div4_stage,
    .channel_clock, .read_phase, .transfer_state_flag_a, .transfer_state_flag_b,
    .substate_flag_a, .substate_flag_b, .peak_transfer, .width_qualified, .crowd_preload);
  trq_station_model u_station (.clk_sys, .req_ch, .req_width, .req_go, .osc_out,
    .read_pulse_in, .busy);

  initial begin
    forever #25 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    pt_prev <= peak_transfer;
    d2p <= div2_stage;
    d4p <= div4_stage;
    if (channel_clock === 1'b1) ticks <= ticks + 1;
    if (div2_stage !== d2p) d2 <= d2 + 1;
    if (div4_stage !== d4p) d4 <= d4 + 1;
    if ((peak_transfer & ~pt_prev) != 9'h000) begin
      xfers <= xfers + 1;
      last_pre <= crowd_preload[req_ch*5 +: 5];
    end
  end

  task automatic check_eq(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check_eq

  task automatic check_rng(input int got, input int lo, input int hi, input string what);
    comparisons++;
    if (got < lo || got > hi) begin
      err_total++;
      $display("MISMATCH t=%0t %s count %0d", $time, what, got);
    end
  endtask : check_rng

  task automatic rates(input logic f, input logic m, input logic s);
    fast_sel <= f;
    mid_sel <= m;
    slow_sel <= s;
    repeat (20) @(posedge clk_sys);
    t0 = ticks;
    a0 = d2;
    b0 = d4;
    repeat (600) @(posedge clk_sys);
    if (f) check_rng(d2 - a0, 99, 101, "div2");
    if (f) check_rng(d4 - b0, 49, 51, "div4");
  endtask : rates

  task automatic send(input int ch, input int wd, input int exp_x);
    int n;
    int x0;
    x0 = xfers;
    @(posedge clk_sys);
    req_ch <= ch[3:0];
    req_width <= wd[7:0];
    req_go <= 1'b1;
    for (n = 0; n < 100 && busy !== 1'b1; n++) @(posedge clk_sys);
    req_go <= 1'b0;
    for (n = 0; n < 3000 && busy !== 1'b0; n++) @(posedge clk_sys);
    repeat (120) @(posedge clk_sys);
    check_eq(xfers - x0, exp_x, "transfers");
    if (exp_x == 1) check_eq(last_pre, ((wd + 1) % 64) / 2, "preload");
  endtask : send

  task automatic seq(input int which, input logic [4:0] exp);
    @(posedge clk_sys);
    case (which)
      0: transfer_start <= 1'b1;
      1: byte_request <= 1'b1;
      2: fm_cycle_done <= 1'b1;
      default: transfer_end <= 1'b1;
    endcase
    @(posedge clk_sys);
    {transfer_start, byte_request, fm_cycle_done, transfer_end} <= 4'h0;
    repeat (2) @(negedge clk_sys);
    check_eq({transfer_state_flag_a, transfer_state_flag_b, substate_flag_a, substate_flag_b,
      read_phase}, exp, "sequencer");
  endtask : seq

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : finish_test

  initial begin
    repeat (80000) @(posedge clk_sys);
    err_total++;
    finish_test();
  end

  initial begin
    repeat (12) @(negedge clk_sys);
    check_eq({div2_stage, peak_transfer, width_qualified, read_phase}, 0, "reset");
    repeat (4) @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    $display("test reset done");
    rates(1'b1, 1'b0, 1'b0);
    check_rng(ticks - t0, 99, 101, "fast ticks");
    rates(1'b0, 1'b1, 1'b0);
    check_rng(ticks - t0, 49, 51, "mid ticks");
    rates(1'b0, 1'b0, 1'b1);
    check_rng(ticks - t0, 0, 0, "slow ticks");
    rates(1'b1, 1'b1, 1'b0);
    $display("test clocks done");
    for (w = 1; w < 7; w++) send(w, w, 0);
    send(8, 8, 1);
    send(0, 63, 1);
    send(4, 70, 1);
    repeat (8) send($unsigned($random(seed)) % 9, 8 + $unsigned($random(seed)) % 50, 1);
    write_order <= 1'b1;
    send(2, 20, 0);
    write_order <= 1'b0;
    crowding_counter_zero[3] <= 1'b0;
    send(3, 12, 0);
    check_eq(width_qualified, 9'h008, "held qualify");
    crowding_counter_zero[3] <= 1'b1;
    repeat (60) @(posedge clk_sys);
    check_eq(last_pre, 5'h06, "late preload");
    check_eq({width_qualified, peak_transfer}, 0, "flags clear");
    $display("test channels done");
    read_order <= 1'b1;
    seq(0, 5'h1f);
    seq(1, 5'h1d);
    seq(2, 5'h1f);
    write_order <= 1'b1;
    seq(1, 5'h1c);
    seq(2, 5'h1e);
    seq(3, 5'h00);
    $display("test sequencer done");
    finish_test();
  end
endmodule : trq_read_qualifier_test
